// *** rtl/aux_addr_bank.sv ***
// auxiliary register bank with pointer and post-access update unit
`include "dsp_addr_cfg.svh"
module aux_addr_bank import dsp_addr_pkg::*; #(
    parameter int NUM_AUX = `NUM_AUX_DEF
) (
    input  wire logic               core_clk,
    input  wire logic               srst,
    input  wire logic               upd_en,
    input  wire logic [2:0]         upd_kind,
    input  wire logic               ptr_load,
    input  wire logic [`PTR_W-1:0]  ptr_new,
    input  wire logic               wr_en,
    input  wire logic [`PTR_W-1:0]  wr_sel,
    input  wire logic [`ADDR_W-1:0] wr_data,
    output logic [`ADDR_W-1:0]      cur_ar,
    output logic [`PTR_W-1:0]       ptr_r
);
    initial begin
        if (NUM_AUX != 5 && NUM_AUX != 8) $error("NUM_AUX must be 5 or 8");
    end

    logic [`ADDR_W-1:0] ar_r [NUM_AUX];
    logic [`ADDR_W-1:0] idx;
    logic [`ADDR_W-1:0] cur_rev;
    logic [`ADDR_W-1:0] idx_rev;
    logic [`ADDR_W-1:0] sum_rev;
    logic [`ADDR_W-1:0] dif_rev;
    logic [`ADDR_W-1:0] br_sum;
    logic [`ADDR_W-1:0] br_dif;
    logic [`ADDR_W-1:0] ar_nxt;

    // absent registers on the small variant read as zero
    assign cur_ar  = (int'(ptr_r) < NUM_AUX) ? ar_r[ptr_r] : `AR_RST;
    assign idx     = ar_r[0];
    assign sum_rev = cur_rev + idx_rev;
    assign dif_rev = cur_rev - idx_rev;

    // bit-reversed carry: reverse, add, reverse back
    for (genvar b = 0; b < `ADDR_W; b++) begin : g_rev
        assign cur_rev[b] = cur_ar[`ADDR_W-1-b];
        assign idx_rev[b] = idx[`ADDR_W-1-b];
        assign br_sum[b]  = sum_rev[`ADDR_W-1-b];
        assign br_dif[b]  = dif_rev[`ADDR_W-1-b];
    end

    // update of the current register after the access
    always_comb begin
        ar_nxt = cur_ar;
        case (aux_update_e'(upd_kind))
            UPD_INC:    ar_nxt = cur_ar + 16'h0001;
            UPD_DEC:    ar_nxt = cur_ar - 16'h0001;
            UPD_ADD0:   ar_nxt = cur_ar + idx;
            UPD_SUB0:   ar_nxt = cur_ar - idx;
            UPD_BR_ADD: ar_nxt = (NUM_AUX == 8) ? br_sum : cur_ar;
            UPD_BR_SUB: ar_nxt = (NUM_AUX == 8) ? br_dif : cur_ar;
            default:    ar_nxt = cur_ar;
        endcase
    end

    // register file; a direct load wins over an update of the same entry
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_AUX; i++) begin
            if (srst) begin
                ar_r[i] <= `AR_RST;
            end else if (wr_en && int'(wr_sel) == i) begin
                ar_r[i] <= wr_data;
            end else if (upd_en && int'(ptr_r) == i) begin
                ar_r[i] <= ar_nxt;
            end
        end
    end

    // pointer changes only after the access has used the old one
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ptr_r <= `PTR_RST;
        end else if (ptr_load) begin
            ptr_r <= ptr_new;
        end
    end
endmodule

// *** rtl/dsp_addr_cfg.svh ***
// constants for operand addressing and repeat control
`ifndef DSP_ADDR_CFG_SVH
`define DSP_ADDR_CFG_SVH
`define ADDR_W        16
`define OFS_W         7
`define PAGE_W        9
`define PAGE_RST      9'h000
`define AR_RST        16'h0000
`define PTR_W         3
`define PTR_RST       3'h0
`define NUM_AUX_DEF   8
`define RPT_CNT_W     8
`define RPT_RST       8'h00
`define MODE_BIT      7
`define UPD_HI        6
`define UPD_LO        4
`define NEWPTR_FLAG   3
`define NEWPTR_HI     2
`define NEWPTR_LO     0
`define BITCODE_HI    11
`define BITCODE_LO    8
`define CMP_HI        1
`define CMP_LO        0
`define PSHIFT_HI     1
`define PSHIFT_LO     0
`define AUXOP_HI      10
`define AUXOP_LO      8
`define STSH_HI       10
`define STSH_LO       8
`define LDSH_HI       11
`define LDSH_LO       8
`define PORT_HI       11
`define PORT_LO       8
`define FMT_BIT       0
`endif

// *** rtl/dsp_addr_pkg.sv ***
// types shared by operand addressing and repeat control
package dsp_addr_pkg;
    // indirect update kinds, as coded in the instruction
    typedef enum logic [2:0] {
        UPD_NONE   = 3'h0,
        UPD_DEC    = 3'h1,
        UPD_INC    = 3'h2,
        UPD_SUB0   = 3'h3,
        UPD_ADD0   = 3'h4,
        UPD_BR_SUB = 3'h5,
        UPD_BR_ADD = 3'h6
    } aux_update_e;
    // repeat sequencer, gray along idle -> armed -> run
    typedef enum logic [1:0] {
        RPT_IDLE  = 2'h0,
        RPT_ARMED = 2'h1,
        RPT_RUN   = 2'h3
    } rpt_state_e;
    // decoded operand fields of one instruction
    typedef struct packed {
        logic       mode_bit;
        logic [3:0] bit_code;
        logic [1:0] compare_kind_field;
        logic [1:0] product_shift_field;
        logic [2:0] aux_operand;
        logic [2:0] store_shift;
        logic [3:0] load_shift;
        logic [3:0] port_number_field;
        logic       format_status_bit;
    } decode_fields_s;
endpackage

// *** rtl/dsp_operand_addressing_repeat.sv ***
// operand address generation, field decode and repeat control
`include "dsp_addr_cfg.svh"

module dsp_operand_addressing_repeat import dsp_addr_pkg::*; #(
    parameter int NUM_AUX = `NUM_AUX_DEF
) (
    input  wire logic                core_clk,
    input  wire logic                srst,
    input  wire logic [15:0]         instr,
    input  wire logic                instr_valid,
    input  wire logic                exec_done,
    input  wire logic                page_load,
    input  wire logic [`PAGE_W-1:0]  page_data,
    input  wire logic                aux_load,
    input  wire logic [`ADDR_W-1:0]  aux_load_data,
    input  wire logic                ptr_load,
    input  wire logic                repeat_from_memory_op,
    input  wire logic                repeat_immediate_op,
    input  wire logic [15:0]         mem_operand,
    output logic [`ADDR_W-1:0]       data_addr_r,
    output logic                     addr_valid_r,
    output decode_fields_s           fields_r,
    output logic [`PAGE_W-1:0]       page_ptr_r,
    output logic [`PTR_W-1:0]        aux_reg_select_pointer,
    output logic [`RPT_CNT_W-1:0]    repeat_counter_register,
    output logic                     fetch_hold_r,
    output logic                     repeat_active_r,
    output logic                     single_cycle_r
);
    // *************************************************
    // elaboration checks
    // *************************************************
    initial begin
        if (NUM_AUX != 5 && NUM_AUX != 8) $error("NUM_AUX must be 5 or 8");
        if (`OFS_W + `PAGE_W != `ADDR_W) $error("page and offset must fill address");
    end

    // *************************************************
    // instruction field split
    // *************************************************
    logic               mode_indirect;
    logic [2:0]         upd_kind;
    logic               newptr_flag;
    logic [`PTR_W-1:0]  newptr;
    logic               ind_access;
    logic [`ADDR_W-1:0] cur_ar;
    decode_fields_s     fields_nxt;

    // one mode bit picks the address source
    assign mode_indirect = instr[`MODE_BIT];
    assign upd_kind      = instr[`UPD_HI:`UPD_LO];
    assign newptr_flag   = instr[`NEWPTR_FLAG];
    assign newptr        = instr[`NEWPTR_HI:`NEWPTR_LO];
    assign ind_access    = instr_valid && mode_indirect;

    // operand fields; each instruction reads only the ones it owns
    always_comb begin
        fields_nxt.mode_bit            = instr[`MODE_BIT];
        fields_nxt.bit_code            = instr[`BITCODE_HI:`BITCODE_LO];
        fields_nxt.compare_kind_field  = instr[`CMP_HI:`CMP_LO];
        fields_nxt.product_shift_field = instr[`PSHIFT_HI:`PSHIFT_LO];
        fields_nxt.aux_operand         = instr[`AUXOP_HI:`AUXOP_LO];
        fields_nxt.store_shift         = instr[`STSH_HI:`STSH_LO];
        fields_nxt.load_shift          = instr[`LDSH_HI:`LDSH_LO];
        fields_nxt.port_number_field   = instr[`PORT_HI:`PORT_LO];
        fields_nxt.format_status_bit   = instr[`FMT_BIT];
    end

    // *************************************************
    // auxiliary register bank
    // *************************************************
    // explicit pointer load uses the same low field as the post-access load
    aux_addr_bank #(
        .NUM_AUX (NUM_AUX)
    ) u_bank (
        .core_clk (core_clk),
        .srst     (srst),
        .upd_en   (ind_access),
        .upd_kind (upd_kind),
        .ptr_load (ptr_load || (ind_access && newptr_flag)),
        .ptr_new  (newptr),
        .wr_en    (aux_load),
        .wr_sel   (instr[`AUXOP_HI:`AUXOP_LO]),
        .wr_data  (aux_load_data),
        .cur_ar   (cur_ar),
        .ptr_r    (aux_reg_select_pointer)
    );

    // *************************************************
    // repeat control
    // *************************************************
    repeat_ctrl #(
        .CNT_W (`RPT_CNT_W)
    ) u_rpt (
        .core_clk    (core_clk),
        .srst        (srst),
        .load_mem    (repeat_from_memory_op),
        .load_imm    (repeat_immediate_op),
        .mem_operand (mem_operand),
        .imm_operand (instr[7:0]),
        .exec_done   (exec_done),
        .count_r     (repeat_counter_register),
        .hold_r      (fetch_hold_r),
        .active_r    (repeat_active_r)
    );

    // *************************************************
    // page pointer and address output
    // *************************************************
    // page pointer: nine bits, one of 512 pages
    always_ff @(posedge core_clk) begin
        if (srst) begin
            page_ptr_r <= `PAGE_RST;
        end else if (page_load) begin
            page_ptr_r <= page_data;
        end
    end

    // address uses the register value from before its update
    always_ff @(posedge core_clk) begin
        if (srst) begin
            data_addr_r  <= '0;
            addr_valid_r <= 1'b0;
        end else begin
            addr_valid_r <= instr_valid;
            if (instr_valid && mode_indirect) begin
                data_addr_r <= cur_ar;
            end else if (instr_valid) begin
                data_addr_r <= {page_ptr_r, instr[`OFS_W-1:0]};
            end
        end
    end

    // decoded fields are latched with the instruction
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fields_r <= '0;
        end else if (instr_valid) begin
            fields_r <= fields_nxt;
        end
    end

    // while repeating, the core issues one iteration per cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            single_cycle_r <= 1'b0;
        end else begin
            single_cycle_r <= repeat_from_memory_op || repeat_immediate_op
                              || (repeat_active_r && !(exec_done
                              && repeat_counter_register == '0));
        end
    end

    // *************************************************
    // checks
    // *************************************************
    // helper: executions seen since the last repeat load
    logic [8:0] exec_cnt_r;
    logic [8:0] load_val_r;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            exec_cnt_r <= '0;
            load_val_r <= '0;
        end else if (repeat_from_memory_op) begin
            exec_cnt_r <= '0;
            load_val_r <= {1'b0, mem_operand[7:0]};
        end else if (repeat_immediate_op) begin
            exec_cnt_r <= '0;
            load_val_r <= {1'b0, instr[7:0]};
        end else if (exec_done && repeat_active_r) begin
            exec_cnt_r <= exec_cnt_r + 9'h001;
        end
    end

    sequence s_direct_issue;
        instr_valid && !instr[`MODE_BIT];
    endsequence

    sequence s_indirect_issue;
        instr_valid && instr[`MODE_BIT] && !aux_load;
    endsequence

    property p_direct_addr;
        @(posedge core_clk) disable iff (srst)
        s_direct_issue |=> data_addr_r == {$past(page_ptr_r), $past(instr[6:0])};
    endproperty
    a_direct_addr: assert property (p_direct_addr)
        else $error("direct address not page over offset");

    property p_page_kept;
        @(posedge core_clk) disable iff (srst)
        page_load ##1 s_direct_issue |=> data_addr_r[15:7] == $past(page_data, 2);
    endproperty
    a_page_kept: assert property (p_page_kept)
        else $error("page bits not from loaded page pointer");

    property p_ptr_load;
        @(posedge core_clk) disable iff (srst)
        (ptr_load || (instr_valid && instr[`MODE_BIT] && !aux_load && instr[3]))
            |=> aux_reg_select_pointer == $past(instr[2:0]);
    endproperty
    a_ptr_load: assert property (p_ptr_load)
        else $error("pointer did not take new value");

    property p_inc;
        @(posedge core_clk) disable iff (srst)
        instr_valid && instr[`MODE_BIT] && !aux_load && instr[6:4] == 3'h2 && !instr[3]
            && !ptr_load && int'(aux_reg_select_pointer) < NUM_AUX
            |=> cur_ar == $past(cur_ar) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc)
        else $error("increment update wrong");

    property p_sub_index;
        @(posedge core_clk) disable iff (srst)
        instr_valid && instr[`MODE_BIT] && !aux_load && instr[6:4] == 3'h3 && !instr[3]
            && !ptr_load && aux_reg_select_pointer != 3'h0
            && int'(aux_reg_select_pointer) < NUM_AUX
            |=> cur_ar == $past(cur_ar) - $past(u_bank.idx);
    endproperty
    a_sub_index: assert property (p_sub_index)
        else $error("subtract index update wrong");

    property p_bitrev_gated;
        @(posedge core_clk) disable iff (srst)
        NUM_AUX != 8 && instr_valid && instr[`MODE_BIT] && !aux_load && instr[6:5] != 2'h0
            && instr[6:4] > 3'h4 && !instr[3] && !ptr_load
            |=> cur_ar == $past(cur_ar);
    endproperty
    a_bitrev_gated: assert property (p_bitrev_gated)
        else $error("bit-reversed update on small variant");

    property p_old_value_used;
        @(posedge core_clk) disable iff (srst)
        s_indirect_issue |=> data_addr_r == $past(cur_ar);
    endproperty
    a_old_value_used: assert property (p_old_value_used)
        else $error("address not taken before update");

    property p_run_count;
        @(posedge core_clk) disable iff (srst)
        $fell(repeat_active_r) && !$past(repeat_from_memory_op)
            && !$past(repeat_immediate_op) |-> exec_cnt_r == load_val_r + 9'h001;
    endproperty
    a_run_count: assert property (p_run_count)
        else $error("repeat ran wrong number of times");

    property p_decrement;
        @(posedge core_clk) disable iff (srst)
        exec_done && repeat_active_r && repeat_counter_register != 8'h00
            && !repeat_from_memory_op && !repeat_immediate_op
            |=> repeat_counter_register == $past(repeat_counter_register) - 8'h01;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("repeat counter did not step down");

    property p_hold;
        @(posedge core_clk) disable iff (srst)
        fetch_hold_r |-> repeat_active_r && repeat_counter_register != 8'h00;
    endproperty
    a_hold: assert property (p_hold)
        else $error("fetch held without repetitions left");

    property p_imm_load;
        @(posedge core_clk) disable iff (srst)
        repeat_immediate_op && !repeat_from_memory_op
            |=> repeat_counter_register == $past(instr[7:0]) ##0 repeat_active_r;
    endproperty
    a_imm_load: assert property (p_imm_load)
        else $error("immediate repeat load wrong");

    property p_fields;
        @(posedge core_clk) disable iff (srst)
        instr_valid |=> fields_r.bit_code == $past(instr[11:8])
            && fields_r.port_number_field == $past(instr[11:8])
            && fields_r.product_shift_field == $past(instr[1:0]);
    endproperty
    a_fields: assert property (p_fields)
        else $error("decoded fields not latched");

    property p_single_cycle;
        @(posedge core_clk) disable iff (srst)
        repeat_active_r && !exec_done && !repeat_from_memory_op
            && !repeat_immediate_op |=> single_cycle_r;
    endproperty
    a_single_cycle: assert property (p_single_cycle)
        else $error("repeat not flagged single cycle");

    property p_compare_field;
        @(posedge core_clk) disable iff (srst)
        instr_valid |=> fields_r.compare_kind_field == $past(instr[1:0]);
    endproperty
    a_compare_field: assert property (p_compare_field)
        else $error("compare kind field not latched");

    property p_aux_operand;
        @(posedge core_clk) disable iff (srst)
        instr_valid |=> fields_r.aux_operand == $past(instr[10:8]);
    endproperty
    a_aux_operand: assert property (p_aux_operand)
        else $error("register operand field not latched");

    property p_shift_fields;
        @(posedge core_clk) disable iff (srst)
        instr_valid |=> fields_r.store_shift == $past(instr[10:8])
            && fields_r.load_shift == $past(instr[11:8]);
    endproperty
    a_shift_fields: assert property (p_shift_fields)
        else $error("shift fields not latched");

    property p_mem_load;
        @(posedge core_clk) disable iff (srst)
        repeat_from_memory_op |=> repeat_counter_register == $past(mem_operand[7:0])
            && repeat_active_r;
    endproperty
    a_mem_load: assert property (p_mem_load)
        else $error("memory repeat load wrong");

    // the last execution must release hold, active and single-cycle together
    property p_release;
        @(posedge core_clk) disable iff (srst)
        repeat_active_r && exec_done && repeat_counter_register == 8'h00
            && !repeat_from_memory_op && !repeat_immediate_op
            |=> !repeat_active_r && !fetch_hold_r && !single_cycle_r;
    endproperty
    a_release: assert property (p_release)
        else $error("repeat did not end after last execution");

    property p_ptr_kept;
        @(posedge core_clk) disable iff (srst)
        !ptr_load && !(instr_valid && instr[`MODE_BIT] && instr[`NEWPTR_FLAG])
            |=> $stable(aux_reg_select_pointer);
    endproperty
    a_ptr_kept: assert property (p_ptr_kept)
        else $error("pointer changed without a load");
endmodule

// *** rtl/repeat_ctrl.sv ***
// repeat counter and sequencer for single-instruction repeat
`include "dsp_addr_cfg.svh"
module repeat_ctrl import dsp_addr_pkg::*; #(
    parameter int CNT_W = `RPT_CNT_W
) (
    input  wire logic             core_clk,
    input  wire logic             srst,
    input  wire logic             load_mem,
    input  wire logic             load_imm,
    input  wire logic [15:0]      mem_operand,
    input  wire logic [7:0]       imm_operand,
    input  wire logic             exec_done,
    output logic [CNT_W-1:0]      count_r,
    output logic                  hold_r,
    output logic                  active_r
);
    initial begin
        if (CNT_W != 8) $error("repeat counter must be 8 bits wide");
    end

    rpt_state_e       state_r;
    rpt_state_e       state_nxt;
    logic [CNT_W-1:0] count_nxt;

    // next state and count; a load restarts the sequence
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        if (load_mem) begin
            state_nxt = RPT_ARMED;
            count_nxt = mem_operand[CNT_W-1:0];
        end else if (load_imm) begin
            state_nxt = RPT_ARMED;
            count_nxt = imm_operand[CNT_W-1:0];
        end else if (exec_done && state_r != RPT_IDLE) begin
            if (count_r == '0) begin
                state_nxt = RPT_IDLE;
            end else begin
                state_nxt = RPT_RUN;
                count_nxt = count_r - 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r  <= RPT_IDLE;
            count_r  <= `RPT_RST;
            hold_r   <= 1'b0;
            active_r <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            count_r  <= count_nxt;
            hold_r   <= state_nxt != RPT_IDLE && count_nxt != '0;
            active_r <= state_nxt != RPT_IDLE;
        end
    end
endmodule

// *** tb/dsp_operand_addressing_repeat_tb.sv ***
// self-checking bench for operand addressing and repeat control
module dsp_operand_addressing_repeat_tb import dsp_addr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, srst, instr_valid, exec_done, page_load, aux_load, ptr_load;
    logic rep_mem, rep_imm, slow, act_q, addr_valid_r, fetch_hold_r;
    logic repeat_active_r, single_cycle_r;
    logic [15:0] instr, aux_load_data, mem_operand, data_addr_r, ar [8];
    logic [8:0] page_data, page_ptr_r, page;
    logic [2:0] ptr, sel_ptr;
    logic [7:0] rcount;
    logic [31:0] rnd;
    decode_fields_s fields_r;
    logic [42:0] q_addr[$], note;
    logic [8:0] q_rep[$];
    int mismatches, comparisons, cycles, execs;
    dsp_operand_addressing_repeat #(.NUM_AUX(8)) dut (
        .core_clk(core_clk), .srst(srst), .instr(instr), .instr_valid(instr_valid),
        .exec_done(exec_done), .page_load(page_load), .page_data(page_data),
        .aux_load(aux_load), .aux_load_data(aux_load_data), .ptr_load(ptr_load),
        .repeat_from_memory_op(rep_mem), .repeat_immediate_op(rep_imm),
        .mem_operand(mem_operand), .data_addr_r(data_addr_r),
        .addr_valid_r(addr_valid_r), .fields_r(fields_r), .page_ptr_r(page_ptr_r),
        .aux_reg_select_pointer(sel_ptr), .repeat_counter_register(rcount),
        .fetch_hold_r(fetch_hold_r), .repeat_active_r(repeat_active_r),
        .single_cycle_r(single_cycle_r));
    fetch_exec_model partner (.core_clk(core_clk), .srst(srst), .slow(slow),
        .active(repeat_active_r), .count(rcount), .exec_done(exec_done));
    // small variant on the same stimulus, watched by its own assertions
    dsp_operand_addressing_repeat #(.NUM_AUX(5)) dut_small (
        .core_clk(core_clk), .srst(srst), .instr(instr), .instr_valid(instr_valid),
        .exec_done(exec_done), .page_load(page_load), .page_data(page_data),
        .aux_load(aux_load), .aux_load_data(aux_load_data), .ptr_load(ptr_load),
        .repeat_from_memory_op(rep_mem), .repeat_immediate_op(rep_imm),
        .mem_operand(mem_operand), .data_addr_r(), .addr_valid_r(), .fields_r(),
        .page_ptr_r(), .aux_reg_select_pointer(), .repeat_counter_register(),
        .fetch_hold_r(), .repeat_active_r(), .single_cycle_r());
    // ****
    // helpers
    // ****
    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic conclude;
        if (mismatches == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask
    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int i = 0; i < 16; i++)
            rev[i] = v[15-i];
    endfunction
    function automatic decode_fields_s dec(input logic [15:0] i);
        return {i[7], i[11:8], i[1:0], i[1:0], i[10:8], i[10:8], i[11:8], i[11:8], i[0]};
    endfunction
    // reference addressing: access with old register, update afterwards
    task automatic issue(input logic [15:0] i);
        logic [15:0] a;
        logic [15:0] x;
        a = i[7] ? ar[ptr] : {page, i[6:0]};
        x = ar[ptr];
        case (i[6:4])
            3'h1: x = x - 16'h0001;
            3'h2: x = x + 16'h0001;
            3'h3: x = x - ar[0];
            3'h4: x = x + ar[0];
            3'h5: x = rev(rev(x) - rev(ar[0]));
            3'h6: x = rev(rev(x) + rev(ar[0]));
            default: ;
        endcase
        if (i[7]) ar[ptr] = x;
        if (i[7] && i[3]) ptr = i[2:0];
        q_addr.push_back({ptr, a, dec(i)});
        instr = i;
        instr_valid = 1'b1;
        step;
    endtask
    task automatic rep(input logic mem, input logic [7:0] n, input logic slw);
        slow = slw;
        q_rep.push_back({1'b0, n});
        mem_operand = {8'hA5, mem ? n : ~n};
        instr = {8'h00, mem ? ~n : n};
        rep_mem = mem;
        rep_imm = !mem;
        step;
        rep_mem = 1'b0;
        rep_imm = 1'b0;
        for (int t = 0; t < 1000 && (t < 2 || repeat_active_r); t++)
            step;
    endtask
    // clock and hang limit
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        while (cycles < 20000) begin
            @(posedge core_clk);
            cycles++;
        end
        mismatches++;
        conclude();
    end
    // monitor: pops the oldest note whenever a result shows
    always @(posedge core_clk) begin
        if (addr_valid_r === 1'b1) begin
            note = q_addr.pop_front();
            check(data_addr_r, note[39:24], "address");
            check(sel_ptr, note[42:40], "pointer");
            check(fields_r, note[23:0], "fields");
        end
        if (repeat_active_r === 1'b1 && act_q === 1'b0) begin
            execs = 0;
            check(rcount, q_rep[0][7:0], "count");
            check({fetch_hold_r, single_cycle_r}, {q_rep[0] != 0, 1'b1}, "hold");
        end
        if (repeat_active_r === 1'b1 && exec_done === 1'b1)
            execs++;
        if (repeat_active_r === 1'b0 && act_q === 1'b1)
            check(execs, q_rep.pop_front() + 1, "executions");
        act_q = repeat_active_r;
    end
    // ****
    // main sequence
    // ****
    initial begin
        srst = 1'b1;
        {instr_valid, page_load, aux_load, ptr_load, rep_mem, rep_imm, slow} = 7'h00;
        {instr, aux_load_data, mem_operand, page_data, ptr} = 0;
        void'($urandom(32'h3975b0fa));
        repeat (5) @(posedge core_clk);
        #1;
        srst = 1'b0;
        check({page_ptr_r, sel_ptr, rcount, fetch_hold_r}, 0, "reset");
        // fill the register bank through the load port
        for (int k = 0; k < 8; k++) begin
            rnd = $urandom;
            ar[k] = rnd[15:0];
            instr = {5'h00, k[2:0], 8'h00};
            aux_load_data = ar[k];
            aux_load = 1'b1;
            step;
        end
        aux_load = 1'b0;
        rnd = $urandom;
        page = rnd[8:0];
        page_data = page;
        page_load = 1'b1;
        ptr = rnd[14:12];
        instr = {13'h0000, ptr};
        ptr_load = 1'b1;
        step;
        {page_load, ptr_load} = 2'b00;
        // direct, back to back, including the last word of the page
        issue(16'hF07F);
        for (int k = 0; k < 8; k++) begin
            rnd = $urandom;
            issue({rnd[15:8], 1'b0, rnd[6:0]});
        end
        // indirect, every update code twice; pointer reloads only on the second pass
        for (int k = 0; k < 16; k++) begin
            rnd = $urandom;
            issue({rnd[15:8], 1'b1, k[2:0], k[3] & rnd[3], rnd[2:0]});
        end
        instr_valid = 1'b0;
        // single run, short, longest, random, prompt and stalling far side
        rep(1'b0, 8'h00, 1'b0);
        rep(1'b1, 8'h03, 1'b1);
        rep(1'b0, 8'hFF, 1'b0);
        rnd = $urandom;
        rep(1'b1, rnd[7:0], 1'b1);
        repeat (4) step;
        check(q_addr.size() + q_rep.size(), 0, "leftover");
        conclude();
    end
endmodule

// *** tb/fetch_exec_model.sv ***
// far-side model: fetch and execute of repeated instructions
module fetch_exec_model (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       slow,
    input  wire logic       active,
    input  wire logic [7:0] count,
    output logic            exec_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic stall_r;
    logic done_r;
    initial begin
        exec_done = 1'b0;
        stall_r = 1'b0;
        done_r = 1'b0;
    end
    // one execution a cycle, or every other cycle when slow
    always @(posedge core_clk) begin
        if (srst || !active) begin
            exec_done <= #1 1'b0;
            done_r <= 1'b0;
            stall_r <= 1'b0;
        end else if (done_r || (exec_done && count == 8'h00)) begin
            exec_done <= #1 1'b0;
            done_r <= 1'b1;
        end else if (slow) begin
            stall_r <= !stall_r;
            exec_done <= #1 stall_r;
        end else begin
            exec_done <= #1 1'b1;
        end
    end
endmodule
